// file: logic/eemc_engine.sv
`timescale 1ns/1ns
module eemc_engine #(
   parameter int COPY_CYCLES =
      eemc_pkg::COPY_TIME_MS * (eemc_pkg::CLK_HZ / 1000),
   parameter int LOAD_CYCLES =
      eemc_pkg::LOAD_TIME_MS * (eemc_pkg::CLK_HZ / 1000)
) (
   input wire logic clk, // 25 MHz
   input wire logic resetn, // Async reset
   input wire logic bus_reset, // Bus reset pulse
   input wire logic cmd_start, // Memory function selected
   input wire logic wr_valid, // Write slot pulse
   input wire logic wr_bit, // Write slot value
   input wire logic rd_slot, // Read slot pulse
   input wire logic spu_on, // Strong pull-up active
   input wire logic [7:0] password_enable_byte, // Enable byte
   input wire logic [63:0] rd_pw_stored, // Stored read password
   input wire logic [63:0] wr_pw_stored, // Stored write password
   input wire logic [7:0] mem_rdata, // Cell array data
   input wire logic mem_ack, // Cell array done
   output logic rd_bit, // Read slot answer
   output logic rd_valid, // Answer strobe
   output logic mem_req, // Cell array request
   output logic mem_we, // Cell array write
   output logic [14:0] mem_addr, // Cell array address
   output logic [7:0] mem_wdata // Cell array write data
);
   import eemc_pkg::*;

   eemc_state_t st_q;
   logic [7:0] sp [0:63];
   logic [2:0] rx_cnt_q;
   logic [7:0] rx_sh_q;
   logic [2:0] tx_cnt_q;
   logic [7:0] tx_sh_q;
   logic [15:0] ta_q;
   logic [5:0] es_q;
   logic partial_q;
   logic accepted_q;
   logic [6:0] ptr_q;
   logic [3:0] idx_q;
   logic ok_q;
   logic vp_sel_q;
   logic [15:0] crc_q;
   logic [TMO_W-1:0] tmo_q;

   logic rx_done;
   logic [7:0] rx_byte;
   logic tx_take;
   logic tx_data;
   logic [7:0] tx_byte;
   logic [7:0] hdr_byte;
   logic [14:0] cur_addr;
   logic [15:0] new_addr;
   logic pw_en;
   logic [2:0] pwi;
   logic [63:0] pw_sel;
   logic match;
   logic ok_n;
   logic is_cp;
   logic skip;
   logic xfer_step;
   logic xfer_last;
   logic sp_we;
   logic [7:0] sp_wd;

   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic pw_loc(input logic [14:0] a);
      return a[14:4] == PW_ROW;
   endfunction

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   assign rx_byte = {wr_bit, rx_sh_q[7:1]};
   assign rx_done = wr_valid && (rx_cnt_q == 3'h7);
   assign tx_take = rd_slot && (tx_cnt_q == 3'h0);
   assign cur_addr = {ta_q[14:6], ptr_q[5:0]};
   assign pw_en = (password_enable_byte == PW_ENABLE);
   assign pwi = 3'(idx_q - HDR_LEN);
   assign ok_n = ok_q & match;
   assign is_cp = (st_q == ST_CP_XFER);

   always_comb begin
      new_addr = {1'b0, rx_byte[6:0], ta_q[7:0]};
      if (st_q == ST_WS_ADDR && pw_loc(new_addr[14:0])) begin
         new_addr[2:0] = 3'h0;
      end
   end

   always_comb begin
      case (idx_q[1:0])
         2'h0: hdr_byte = ta_q[7:0];
         2'h1: hdr_byte = ta_q[15:8];
         default: hdr_byte = {accepted_q, partial_q, es_q};
      endcase
   end

   always_comb begin
      if (st_q == ST_CP_RX || (st_q == ST_VP_RX && vp_sel_q)) begin
         pw_sel = wr_pw_stored;
      end else begin
         pw_sel = rd_pw_stored;
      end
      if (idx_q < HDR_LEN) begin
         // Only copy checks the echoed header; others send an address
         match = (st_q != ST_CP_RX) || (rx_byte == hdr_byte);
      end else begin
         // Stored form is scrambled, so compare scrambled forms
         match = (!pw_en && st_q != ST_VP_RX) ||
                 ((rx_byte ^ SCR_KEY[{pwi, 3'h0} +: 8]) ==
                  pw_sel[{pwi, 3'h0} +: 8]);
      end
   end

   always_comb begin
      tx_data = ((st_q == ST_RS) && (idx_q < HDR_LEN || !ptr_q[6])) ||
                ((st_q == ST_RM_READ) && !ptr_q[6]);
      case (st_q)
         ST_RS, ST_RM_READ, ST_WS_DATA: begin
            if (st_q == ST_RS && idx_q < HDR_LEN) begin
               tx_byte = hdr_byte;
            end else if (!ptr_q[6] && st_q != ST_WS_DATA) begin
               tx_byte = sp[ptr_q[5:0]];
            end else if (ptr_q == SP_CRC_LO) begin
               tx_byte = ~crc_q[7:0];
            end else if (ptr_q == SP_CRC_HI) begin
               tx_byte = ~crc_q[15:8];
            end else begin
               tx_byte = ALL_ONES;
            end
         end
         ST_RV_READ: begin
            tx_byte = (idx_q < 4'h2) ? (VERSION & VER_MASK) : ALL_ONES;
         end
         ST_OK: tx_byte = OK_PATTERN;
         default: tx_byte = ALL_ONES;
      endcase
   end

   always_comb begin
      if (is_cp) begin
         skip = (cur_addr > LAST_USER);
         xfer_last = (ptr_q[5:0] == es_q);
      end else begin
         skip = pw_loc(cur_addr) || (cur_addr > LAST_USER);
         xfer_last = (ptr_q[5:0] == SP_LAST);
      end
      xfer_step = mem_req ? mem_ack : skip;
      sp_we = 1'b0;
      sp_wd = rx_byte;
      if (st_q == ST_WS_DATA && rx_done && !ptr_q[6]) begin
         sp_we = 1'b1;
      end else if (st_q == ST_RM_XFER && spu_on && xfer_step) begin
         sp_we = 1'b1;
         sp_wd = mem_req ? mem_rdata : ALL_ONES;
      end
   end

   // ---------------------------------------------
   // Bit receiver and bit sender
   // ---------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_cnt_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end else if (bus_reset) begin
         rx_cnt_q <= 3'h0;
      end else if (wr_valid) begin
         rx_sh_q <= rx_byte;
         rx_cnt_q <= rx_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_cnt_q <= 3'h0;
         tx_sh_q <= 8'hFF;
         rd_bit <= 1'b1;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_slot && !bus_reset;
         if (bus_reset) begin
            tx_cnt_q <= 3'h0;
         end else if (tx_take) begin
            rd_bit <= tx_byte[0];
            tx_sh_q <= {1'b1, tx_byte[7:1]};
            tx_cnt_q <= 3'h7;
         end else if (rd_slot) begin
            rd_bit <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            tx_cnt_q <= tx_cnt_q - 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sp_we) begin
         sp[ptr_q[5:0]] <= sp_wd;
      end
   end

   // ---------------------------------------------
   // Command sequencer
   // ---------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_WAIT;
         ta_q <= TA_RST;
         es_q <= ES_RST;
         partial_q <= PARTIAL_RST;
         accepted_q <= ACCEPTED_RST;
         crc_q <= CRC_RST;
         ptr_q <= 7'h00;
         idx_q <= 4'h0;
         ok_q <= 1'b1;
         vp_sel_q <= 1'b0;
         tmo_q <= '0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 15'h0000;
         mem_wdata <= 8'h00;
      end else if (bus_reset) begin
         st_q <= ST_WAIT;
         mem_req <= 1'b0;
         if (st_q == ST_WS_DATA && rx_cnt_q != 3'h0) begin
            partial_q <= 1'b1;
         end
      end else begin
         case (st_q)
            ST_WAIT: if (cmd_start) begin
               st_q <= ST_CMD;
            end
            ST_CMD: if (rx_done) begin
               crc_q <= crc_byte(CRC_RST, rx_byte);
               ok_q <= 1'b1;
               idx_q <= (rx_byte == CMD_CP || rx_byte == CMD_RS) ?
                        4'h0 : 4'h1;
               ptr_q <= {1'b0, ta_q[5:0]};
               case (rx_byte)
                  CMD_WS: begin
                     accepted_q <= 1'b0;
                     st_q <= ST_WS_ADDR;
                  end
                  CMD_RS: st_q <= ST_RS;
                  CMD_CP: st_q <= ST_CP_RX;
                  CMD_RM: st_q <= ST_RM_RX;
                  CMD_VP: st_q <= ST_VP_RX;
                  CMD_RV: st_q <= ST_RV_RX;
                  default: st_q <= ST_ONES;
               endcase
            end
            ST_WS_ADDR, ST_RM_RX, ST_VP_RX, ST_RV_RX, ST_CP_RX: begin
               if (rx_done) begin
                  idx_q <= idx_q + 4'h1;
                  ok_q <= ok_n;
                  if (st_q == ST_WS_ADDR || st_q == ST_RM_RX) begin
                     if (idx_q == 4'h1) begin
                        ta_q[7:0] <= rx_byte;
                        crc_q <= crc_byte(crc_q, rx_byte);
                     end else if (idx_q == 4'h2) begin
                        ta_q <= new_addr;
                        ptr_q <= {1'b0, new_addr[5:0]};
                        crc_q <= crc_byte(crc_q, rx_byte);
                        if (st_q == ST_WS_ADDR) begin
                           st_q <= ST_WS_DATA;
                        end
                     end
                  end
                  if (st_q == ST_VP_RX && idx_q == 4'h1) begin
                     vp_sel_q <= rx_byte[3];
                  end
                  if (st_q == ST_RV_RX && idx_q == 4'h2) begin
                     idx_q <= 4'h0;
                     st_q <= ST_RV_READ;
                  end
                  if (idx_q == PW_LAST_IDX) begin
                     case (st_q)
                        ST_CP_RX: st_q <= ok_n ? ST_CP_WAIT : ST_ONES;
                        ST_RM_RX: st_q <= ok_n ? ST_RM_WAIT : ST_ONES;
                        default: st_q <= ok_n ? ST_OK : ST_ONES;
                     endcase
                  end
               end
            end
            ST_WS_DATA: begin
               if (rx_done && !ptr_q[6]) begin
                  crc_q <= crc_byte(crc_q, rx_byte);
                  ptr_q <= ptr_q + 7'h01;
                  if (!pw_loc(cur_addr) || ptr_q[2:0] == 3'h7) begin
                     es_q <= ptr_q[5:0];
                     partial_q <= 1'b0;
                  end else begin
                     partial_q <= 1'b1;
                  end
               end else if (tx_take && ptr_q[6] && ptr_q < 7'h42) begin
                  ptr_q <= ptr_q + 7'h01;
               end
            end
            ST_RS, ST_RM_READ: if (tx_take) begin
               if (tx_data) begin
                  crc_q <= crc_byte(crc_q, tx_byte);
               end
               if (st_q == ST_RS && idx_q < HDR_LEN) begin
                  idx_q <= idx_q + 4'h1;
               end else if (ptr_q < 7'h42) begin
                  ptr_q <= ptr_q + 7'h01;
               end
               if (st_q == ST_RM_READ && ptr_q == SP_CRC_HI) begin
                  crc_q <= CRC_RST;
                  ta_q <= {1'b0, ta_q[14:6] + 9'h001, 6'h00};
                  st_q <= (ta_q[14:6] == LAST_PAGE) ? ST_ONES :
                          ST_RM_WAIT;
               end
            end
            ST_CP_WAIT, ST_RM_WAIT: if (spu_on) begin
               ptr_q <= {1'b0, ta_q[5:0]};
               if (st_q == ST_CP_WAIT) begin
                  accepted_q <= 1'b1;
                  tmo_q <= TMO_W'(COPY_CYCLES);
                  st_q <= ST_CP_XFER;
               end else begin
                  tmo_q <= TMO_W'(LOAD_CYCLES);
                  st_q <= ST_RM_XFER;
               end
            end
            ST_CP_XFER, ST_RM_XFER: begin
               tmo_q <= tmo_q - TMO_W'(1);
               if (!spu_on || tmo_q == '0) begin
                  mem_req <= 1'b0;
                  st_q <= ST_ONES;
               end else if (xfer_step) begin
                  mem_req <= 1'b0;
                  if (!xfer_last) begin
                     ptr_q <= ptr_q + 7'h01;
                  end else if (is_cp) begin
                     st_q <= ST_OK;
                  end else begin
                     ptr_q <= {1'b0, ta_q[5:0]};
                     st_q <= ST_RM_READ;
                  end
               end else if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= is_cp;
                  mem_addr <= cur_addr;
                  mem_wdata <= sp[ptr_q[5:0]] ^ ((is_cp && pw_loc(cur_addr))
                     ? SCR_KEY[{ptr_q[2:0], 3'h0} +: 8] : 8'h00);
               end
            end
            ST_RV_READ: if (tx_take && idx_q < 4'h2) begin
               idx_q <= idx_q + 4'h1;
            end
            ST_OK, ST_ONES: st_q <= st_q;
            default: st_q <= ST_WAIT;
         endcase
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_ws_code;
      st_q == ST_CMD && rx_done && rx_byte == CMD_WS && !bus_reset;
   endsequence

   sequence s_ws_enter;
      !accepted_q && st_q == ST_WS_ADDR;
   endsequence

   AST_WS_CLR_AA: assert property (s_ws_code |=> s_ws_enter)
      else $error("write command kept accepted flag");
   AST_MSB_CLR: assert property (!ta_q[15] && (!mem_addr[14] ||
      mem_addr <= LAST_USER))
      else $error("target address top bit set");
   AST_PW_ALIGN: assert property ((st_q == ST_WS_DATA &&
      ta_q[14:4] == PW_ROW) |-> ta_q[2:0] == 3'h0)
      else $error("password target not aligned");
   AST_PARTIAL: assert property ((bus_reset && st_q == ST_WS_DATA &&
      rx_cnt_q != 3'h0) |=> partial_q && st_q == ST_WAIT)
      else $error("partial byte not flagged");
   AST_ONES: assert property ((st_q == ST_ONES && rd_slot &&
      !bus_reset) |=> rd_bit && rd_valid)
      else $error("ones state answered zero");
   AST_OK_LSB: assert property ((st_q == ST_OK && tx_take &&
      !bus_reset) |=> !rd_bit ##0 rd_valid)
      else $error("success pattern wrong");
   AST_ACC_COPY: assert property (st_q == ST_CP_XFER |-> accepted_q)
      else $error("copy without accepted flag");
   AST_RESERVED: assert property (mem_req |-> mem_addr <= LAST_USER)
      else $error("reserved range touched");
   AST_HIDE_PW: assert property ((mem_req && !mem_we) |->
      mem_addr[14:4] != PW_ROW)
      else $error("password location read");
   AST_SPU_LOSS: assert property ((st_q == ST_CP_XFER && !spu_on &&
      !bus_reset) |=> st_q == ST_ONES ##1 st_q == ST_ONES)
      else $error("copy survived pull-up loss");
endmodule

// file: pkg/eemc_pkg.sv
package eemc_pkg;
   localparam logic [7:0] CMD_WS = 8'h0F;
   localparam logic [7:0] CMD_RS = 8'hAA;
   localparam logic [7:0] CMD_CP = 8'h99;
   localparam logic [7:0] CMD_RM = 8'h69;
   localparam logic [7:0] CMD_VP = 8'hC3;
   localparam logic [7:0] CMD_RV = 8'hCC;
   localparam logic [7:0] PW_ENABLE = 8'hAA;
   localparam logic [7:0] OK_PATTERN = 8'hAA;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [10:0] PW_ROW = 11'h7FC;
   localparam logic [14:0] LAST_USER = 15'h7FD0;
   localparam logic [8:0] LAST_PAGE = 9'h1FF;
   localparam logic [5:0] SP_LAST = 6'h3F;
   localparam logic [6:0] SP_CRC_LO = 7'h40;
   localparam logic [6:0] SP_CRC_HI = 7'h41;
   localparam logic [3:0] PW_LAST_IDX = 4'hA;
   localparam logic [3:0] HDR_LEN = 4'h3;
   localparam logic [7:0] VER_MASK = 8'hE0;
   // Arbitrary revision value
   localparam logic [7:0] VERSION = 8'h00;
   // Arbitrary scrambler key
   localparam logic [63:0] SCR_KEY = 64'h3C5A96E1D2874B0F;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RST = 16'h0000;
   localparam logic [15:0] TA_RST = 16'h0000;
   localparam logic [5:0] ES_RST = 6'h00;
   localparam logic PARTIAL_RST = 1'b1;
   localparam logic ACCEPTED_RST = 1'b0;
   localparam int CLK_HZ = 25000000;
   localparam int COPY_TIME_MS = 10;
   localparam int LOAD_TIME_MS = 5;
   localparam int TMO_W = 18;
   typedef enum logic [4:0] {
      ST_WAIT = 5'h00, ST_CMD = 5'h01, ST_WS_ADDR = 5'h02,
      ST_WS_DATA = 5'h03, ST_RS = 5'h04, ST_CP_RX = 5'h05,
      ST_CP_WAIT = 5'h06, ST_CP_XFER = 5'h07, ST_RM_RX = 5'h08,
      ST_RM_WAIT = 5'h09, ST_RM_XFER = 5'h0A, ST_RM_READ = 5'h0B,
      ST_VP_RX = 5'h0C, ST_RV_RX = 5'h0D, ST_RV_READ = 5'h0E,
      ST_OK = 5'h0F, ST_ONES = 5'h10
   } eemc_state_t;
endpackage

// file: verif/eemc_mem_model.sv
`timescale 1ns/1ns
module eemc_mem_model #(
   parameter int DELAY = 3
) (
   input wire logic clk, // Clock
   input wire logic resetn, // Async reset
   input wire logic mem_req, // Request level
   input wire logic mem_we, // Write select
   input wire logic [14:0] mem_addr, // Byte address
   input wire logic [7:0] mem_wdata, // Write data
   output logic [7:0] mem_rdata, // Read data
   output logic mem_ack // Done pulse
);
   logic [7:0] cells [0:32767];
   int wait_q;

   initial begin
      for (int i = 0; i < 32768; i++) begin
         cells[i] = i[7:0] ^ 8'h5A;
      end
   end

   // Slow answer, data scrambled outside the ack cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 0;
         mem_ack <= 1'b0;
         mem_rdata <= 8'h00;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && wait_q < DELAY) begin
            wait_q <= wait_q + 1;
         end else if (mem_req && !mem_ack) begin
            wait_q <= 0;
            mem_ack <= 1'b1;
            mem_rdata <= cells[mem_addr];
            if (mem_we) begin
               cells[mem_addr] <= mem_wdata;
            end
         end else if (!mem_req) begin
            wait_q <= 0;
         end
      end
   end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
   import eemc_pkg::*;
   localparam logic [63:0] RP = 64'h1122334455667788;
   localparam logic [63:0] WP = 64'h99AABBCCDDEEFF00;
   typedef struct {
      logic [15:0] addr;
      int n;
      logic [15:0] ta;
      logic [7:0] es;
   } eemc_row_t;
   typedef struct {
      logic [7:0] code;
      logic [15:0] addr;
      logic [63:0] pw;
      logic [7:0] en;
      logic [7:0] exp;
   } eemc_pw_t;
   logic clk, resetn, bus_reset, cmd_start, wr_valid, wr_bit, rd_slot;
   logic spu_on, mem_ack, rd_bit, rd_valid, mem_req, mem_we;
   logic [7:0] password_enable_byte, mem_rdata, mem_wdata, b;
   logic [14:0] mem_addr;
   logic [15:0] crc;
   int failures, check_count;
   eemc_row_t rows [3] = '{
      '{16'h0010, 4, 16'h0010, 8'h13},
      '{16'h803C, 4, 16'h003C, 8'h3F},
      '{16'h7FC3, 8, 16'h7FC0, 8'h07}};
   eemc_pw_t pws [8] = '{
      '{CMD_RM, 16'h00BE, RP, PW_ENABLE, 8'hE4},
      '{CMD_RM, 16'h00BE, WP, PW_ENABLE, 8'hFF},
      '{CMD_RM, 16'h00BE, WP, 8'h00, 8'hE4},
      '{CMD_RM, 16'h7FC0, RP, 8'h00, 8'hFF},
      '{CMD_VP, 16'h7FC0, RP, 8'h00, OK_PATTERN},
      '{CMD_VP, 16'h7FC0, WP, 8'h00, 8'hFF},
      '{CMD_VP, 16'h7FC8, WP, PW_ENABLE, OK_PATTERN},
      '{8'h55, 16'h0000, RP, 8'h00, 8'hFF}};

   eemc_engine #(.COPY_CYCLES(200), .LOAD_CYCLES(200)) u_dut (
      .clk(clk), .resetn(resetn), .bus_reset(bus_reset),
      .cmd_start(cmd_start), .wr_valid(wr_valid), .wr_bit(wr_bit),
      .rd_slot(rd_slot), .spu_on(spu_on),
      .password_enable_byte(password_enable_byte),
      .rd_pw_stored(RP ^ SCR_KEY), .wr_pw_stored(WP ^ SCR_KEY),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .rd_bit(rd_bit),
      .rd_valid(rd_valid), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata));

   eemc_mem_model u_mem (
      .clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));

   // ----
   // Helpers
   // ----
   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ v[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic sb(input logic [7:0] v, input int n = 8);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         wr_valid = 1'b1;
         wr_bit = v[i];
      end
      @(negedge clk);
      wr_valid = 1'b0;
      if (n == 8) begin
         crc = crc_step(crc, v);
      end
   endtask

   task automatic rb(output logic [7:0] v);
      int k;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         rd_slot = 1'b1;
         @(negedge clk);
         rd_slot = 1'b0;
         for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge clk);
         if (k == 4) begin
            failures++;
            finish_test();
         end
         v[i] = rd_bit;
      end
   endtask

   task automatic rdc(input string what, input logic [7:0] exp);
      rb(b);
      crc = crc_step(crc, b);
      chk(what, exp, b);
   endtask

   task automatic rcrc(input string what);
      logic [15:0] e;
      e = ~crc;
      rb(b);
      chk(what, e[7:0], b);
      rb(b);
      chk(what, e[15:8], b);
   endtask

   task automatic start(input logic [7:0] code);
      @(negedge clk);
      bus_reset = 1'b1;
      @(negedge clk);
      bus_reset = 1'b0;
      cmd_start = 1'b1;
      @(negedge clk);
      cmd_start = 1'b0;
      crc = CRC_RST;
      sb(code);
   endtask

   task automatic power(input int n = 500);
      spu_on = 1'b1;
      repeat (n) @(negedge clk);
      spu_on = 1'b0;
   endtask

   task automatic rs_head(input logic [15:0] ta, input logic [7:0] es);
      start(CMD_RS);
      rdc("ta_low", ta[7:0]);
      rdc("ta_high", ta[15:8]);
      rdc("status", es);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----
   // Main sequence
   // ----
   initial begin
      resetn = 1'b0;
      bus_reset = 1'b0;
      cmd_start = 1'b0;
      wr_valid = 1'b0;
      wr_bit = 1'b0;
      rd_slot = 1'b0;
      spu_on = 1'b0;
      password_enable_byte = 8'h00;
      crc = CRC_RST;
      failures = 0;
      check_count = 0;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      rs_head(16'h0000, 8'h40);
      foreach (rows[r]) begin
         start(CMD_WS);
         sb(rows[r].addr[7:0]);
         sb(rows[r].addr[15:8]);
         for (int i = 0; i < rows[r].n; i++) sb(8'h10 + i[7:0]);
         rs_head(rows[r].ta, rows[r].es);
         for (int i = 0; i < rows[r].n; i++) rdc("sp", 8'h10 + i[7:0]);
      end
      // Incomplete last byte
      start(CMD_WS);
      sb(8'h00);
      sb(8'h02);
      sb(8'h11);
      sb(8'h22, 3);
      rs_head(16'h0200, 8'h40);
      start(CMD_WS);
      sb(8'h00);
      sb(8'h02);
      sb(8'h11);
      rs_head(16'h0200, 8'h00);
      // Full tail write with both CRCs
      start(CMD_WS);
      sb(8'h3C);
      sb(8'h01);
      for (int i = 0; i < 4; i++) sb(8'hC0 + i[7:0]);
      rcrc("write_crc");
      rs_head(16'h013C, 8'h3F);
      for (int i = 0; i < 4; i++) rdc("sp", 8'hC0 + i[7:0]);
      rcrc("read_crc");
      // Copy refused, then accepted
      start(CMD_CP);
      sb(8'h3C);
      sb(8'h02);
      sb(8'h3F);
      repeat (8) sb(8'h00);
      power();
      rdc("copy_bad", ALL_ONES);
      start(CMD_CP);
      sb(8'h3C);
      sb(8'h01);
      sb(8'h3F);
      repeat (8) sb(8'h00);
      power();
      rdc("copy_ok", OK_PATTERN);
      rdc("copy_ok", OK_PATTERN);
      for (int i = 0; i < 4; i++) begin
         chk("cell", 8'hC0 + i[7:0], u_mem.cells[15'h013C + i]);
      end
      chk("cell_next", 8'h40 ^ 8'h5A, u_mem.cells[15'h0140]);
      rs_head(16'h013C, 8'hBF);
      start(CMD_WS);
      sb(8'h3C);
      sb(8'h01);
      sb(8'h77);
      rs_head(16'h013C, 8'h3C);
      // Copy cut short by pull-up loss
      start(CMD_CP);
      sb(8'h3C);
      sb(8'h01);
      sb(8'h3C);
      repeat (8) sb(8'h00);
      power(3);
      rdc("copy_cut", ALL_ONES);
      // Password row copy stores scrambled bytes
      start(CMD_WS);
      sb(8'hC0);
      sb(8'h7F);
      for (int i = 0; i < 8; i++) sb(8'h30 + i[7:0]);
      start(CMD_CP);
      sb(8'hC0);
      sb(8'h7F);
      sb(8'h07);
      repeat (8) sb(8'h00);
      power();
      rdc("pw_copy", OK_PATTERN);
      for (int i = 0; i < 8; i++) begin
         b = (8'h30 + i[7:0]) ^ SCR_KEY[8*i +: 8];
         chk("pw_cell", b, u_mem.cells[15'h7FC0 + i]);
      end
      // Password commands
      foreach (pws[p]) begin
         password_enable_byte = pws[p].en;
         start(pws[p].code);
         sb(pws[p].addr[7:0]);
         sb(pws[p].addr[15:8]);
         for (int i = 0; i < 8; i++) sb(pws[p].pw[8*i +: 8]);
         if (pws[p].code == CMD_RM) begin
            power();
         end
         rdc("pw_cmd", pws[p].exp);
      end
      // Reset in mid-run restores status
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      rs_head(16'h0000, 8'h40);
      // Version read
      start(CMD_RV);
      sb(8'h00);
      sb(8'h00);
      rdc("version", VERSION & VER_MASK);
      rdc("version", VERSION & VER_MASK);
      rdc("version_end", ALL_ONES);
      finish_test();
   end
endmodule
